// ### rffc_pkg.sv
// Purpose: Shared constants and types for the reader FIFO flow control block
// Assumes: Host register access arrives already decoded from the host interface
// Notes: Fill level fits five bits since the buffer holds at most 24 bytes
package rffc_pkg;
   localparam logic [4:0] ADDR_TXLEN_LO = 5'h1D;
   localparam logic [4:0] ADDR_TXLEN_HI = 5'h1E;
   localparam logic [4:0] ADDR_FIFO = 5'h1F;
   localparam logic [7:0] CMD_RESET_FIFO = 8'h0F;
   localparam int DEPTH = 24;
   localparam int CNT_W = 12;
   localparam logic [4:0] PTR_LAST = 5'h17;
   localparam logic [11:0] LEVEL_FULL = 12'h018;
   localparam logic [11:0] LEVEL_LOW = 12'h006;
   localparam logic [11:0] LEVEL_HIGH = 12'h012;
   localparam logic [11:0] CNT_RST = 12'h000;
   localparam logic [11:0] TXLEN_RST = 12'h000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } rffc_host_req_s;

   typedef struct packed {
      logic high_level;
      logic low_level;
      logic overflow;
      logic [4:0] fill;
   } rffc_status_s;
endpackage : rffc_pkg

// ### rffc_fifo.sv
// Purpose: 24-byte FIFO with counters, level requests and transmit length control
// Assumes: Host accesses and command strobes are single-cycle pulses on CLK
// Notes: LINK_CLK comes from the transmit coder; each rising edge takes one byte
//
// How it works
// - Host writes to the data address fill locations 0..23, wrapping to 0.
// - Reset FIFO command clears contents and both pointers before each transmission.
// - Input counter increments once per byte loaded into the FIFO.
// - Output counter increments once per byte removed from the FIFO.
// - Both byte counters are twelve bits and govern data flow.
// - Request raised while fewer than six bytes are held during transmission.
// - Request raised while more than eighteen bytes are held during reception.
// - Bytes passed to transmission never exceed the programmed transmit length.
// - Transmit logic is told when the final byte leaves the FIFO.
// - Status shows the byte count plus three flags.
// - Overflow flag sets when a byte is written into a full FIFO.
// - Low-level flag sets when the level is low during transmission.
// - High-level flag sets when the level is high during reception.
`timescale 1ns/1ns
`default_nettype none
module rffc_fifo (
   input wire logic CLK,
   input wire logic RESETN,
   input wire rffc_pkg::rffc_host_req_s HOST_REQ,
   output logic [7:0] HOST_RDATA,
   input wire logic CMD_STB,
   input wire logic [7:0] CMD_CODE,
   input wire logic TX_ACTIVE,
   input wire logic RX_ACTIVE,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic LINK_CLK,
   output logic [7:0] TX_DATA,
   output logic TX_VALID,
   output logic TX_LAST,
   output logic IRQ_LOW,
   output logic IRQ_HIGH,
   output rffc_pkg::rffc_status_s STATUS
);
   function automatic logic [4:0] ptr_next(input logic [4:0] p);
      ptr_next = (p == rffc_pkg::PTR_LAST) ? 5'h00 : p + 5'h01;
   endfunction : ptr_next

   logic [7:0] mem_q [rffc_pkg::DEPTH];
   logic [4:0] wr_ptr_q, rd_ptr_q;
   logic [11:0] in_cnt_q, out_cnt_q, txlen_q;
   logic ove_q, lol_q, hil_q;
   logic lk_s1_q, lk_s2_q, lk_s3_q;
   logic [7:0] buf0_q, buf1_q;
   logic [1:0] bcnt_q;
   logic [7:0] rdata_q;
   logic last_q, irq_lo_q, irq_hi_q;

   // Decoding
   wire fifo_clr = CMD_STB && (CMD_CODE == rffc_pkg::CMD_RESET_FIFO);
   wire hw_fifo = HOST_REQ.wr && (HOST_REQ.addr == rffc_pkg::ADDR_FIFO);
   wire hr_fifo = HOST_REQ.rd && (HOST_REQ.addr == rffc_pkg::ADDR_FIFO);
   wire hw_lo = HOST_REQ.wr && (HOST_REQ.addr == rffc_pkg::ADDR_TXLEN_LO);
   wire hw_hi = HOST_REQ.wr && (HOST_REQ.addr == rffc_pkg::ADDR_TXLEN_HI);
   wire [11:0] level = in_cnt_q - out_cnt_q;
   wire full = (level == rffc_pkg::LEVEL_FULL);
   wire empty = (level == rffc_pkg::CNT_RST);
   wire rx_try = RX_VALID && RX_ACTIVE && !hw_fifo;
   wire push = (hw_fifo || rx_try) && !full;
   wire [7:0] push_data = hw_fifo ? HOST_REQ.wdata : RX_DATA;
   wire pop_host = hr_fifo && !empty;
   wire link_rise = lk_s2_q && !lk_s3_q;
   wire drain = link_rise && (bcnt_q != 2'd0);
   wire buf_in_ready = (bcnt_q != 2'd2) || drain;
   wire tx_allow = (out_cnt_q < txlen_q);
   wire pop_tx = TX_ACTIVE && !empty && !pop_host && buf_in_ready && tx_allow && !fifo_clr;
   wire pop = pop_host || pop_tx;
   wire ove_set = (hw_fifo || rx_try) && full;
   wire lol_set = TX_ACTIVE && (level < rffc_pkg::LEVEL_LOW);
   wire hil_set = RX_ACTIVE && (level > rffc_pkg::LEVEL_HIGH);
   wire last_d = pop_tx && ((out_cnt_q + 12'h001) == txlen_q);
   wire [7:0] rd_mux = hr_fifo ? (empty ? rffc_pkg::BYTE_RST : mem_q[rd_ptr_q]) :
                       (HOST_REQ.addr == rffc_pkg::ADDR_TXLEN_LO) ? txlen_q[7:0] :
                       (HOST_REQ.addr == rffc_pkg::ADDR_TXLEN_HI) ? {4'h0, txlen_q[11:8]} :
                       rffc_pkg::BYTE_RST;

   // Link clock synchroniser
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         lk_s1_q <= 1'b0;
         lk_s2_q <= 1'b0;
         lk_s3_q <= 1'b0;
      end else begin
         lk_s1_q <= LINK_CLK;
         lk_s2_q <= lk_s1_q;
         lk_s3_q <= lk_s2_q;
      end
   end

   // Storage array
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         for (int i = 0; i < rffc_pkg::DEPTH; i++) mem_q[i] <= rffc_pkg::BYTE_RST;
      end else if (fifo_clr) begin
         for (int i = 0; i < rffc_pkg::DEPTH; i++) mem_q[i] <= rffc_pkg::BYTE_RST;
      end else if (push) begin
         mem_q[wr_ptr_q] <= push_data;
      end
   end

   // Pointers and counters
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_ptr_q <= 5'h00;
         rd_ptr_q <= 5'h00;
         in_cnt_q <= rffc_pkg::CNT_RST;
         out_cnt_q <= rffc_pkg::CNT_RST;
      end else if (fifo_clr) begin
         wr_ptr_q <= 5'h00;
         rd_ptr_q <= 5'h00;
         in_cnt_q <= rffc_pkg::CNT_RST;
         out_cnt_q <= rffc_pkg::CNT_RST;
      end else begin
         if (push) begin
            wr_ptr_q <= ptr_next(wr_ptr_q);
            in_cnt_q <= in_cnt_q + 12'h001;
         end
         if (pop) begin
            rd_ptr_q <= ptr_next(rd_ptr_q);
            out_cnt_q <= out_cnt_q + 12'h001;
         end
      end
   end

   // Transmit length, written by the host ahead of the data
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         txlen_q <= rffc_pkg::TXLEN_RST;
      end else begin
         if (hw_lo) txlen_q[7:0] <= HOST_REQ.wdata;
         if (hw_hi) txlen_q[11:8] <= HOST_REQ.wdata[3:0];
      end
   end

   // Sticky flags; a set in the clearing cycle wins
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ove_q <= 1'b0;
         lol_q <= 1'b0;
         hil_q <= 1'b0;
      end else begin
         ove_q <= ove_set || (ove_q && !fifo_clr);
         lol_q <= lol_set || (lol_q && !fifo_clr);
         hil_q <= hil_set || (hil_q && !fifo_clr);
      end
   end

   // Two-entry buffer toward the transmit coder
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         buf0_q <= rffc_pkg::BYTE_RST;
         buf1_q <= rffc_pkg::BYTE_RST;
         bcnt_q <= 2'd0;
      end else if (fifo_clr) begin
         bcnt_q <= 2'd0;
      end else begin
         case ({pop_tx, drain})
            2'b11: begin
               buf0_q <= (bcnt_q == 2'd1) ? mem_q[rd_ptr_q] : buf1_q;
               buf1_q <= mem_q[rd_ptr_q];
            end
            2'b10: begin
               if (bcnt_q == 2'd0) buf0_q <= mem_q[rd_ptr_q];
               else buf1_q <= mem_q[rd_ptr_q];
               bcnt_q <= bcnt_q + 2'd1;
            end
            2'b01: begin
               buf0_q <= buf1_q;
               bcnt_q <= bcnt_q - 2'd1;
            end
            default: begin
               bcnt_q <= bcnt_q;
            end
         endcase
      end
   end

   // Registered outputs
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_q <= rffc_pkg::BYTE_RST;
         last_q <= 1'b0;
         irq_lo_q <= 1'b0;
         irq_hi_q <= 1'b0;
      end else begin
         if (HOST_REQ.rd) rdata_q <= rd_mux;
         last_q <= last_d;
         irq_lo_q <= TX_ACTIVE && (level < rffc_pkg::LEVEL_LOW);
         irq_hi_q <= RX_ACTIVE && (level > rffc_pkg::LEVEL_HIGH);
      end
   end

   assign HOST_RDATA = rdata_q;
   assign TX_DATA = buf0_q;
   assign TX_VALID = (bcnt_q != 2'd0);
   assign TX_LAST = last_q;
   assign IRQ_LOW = irq_lo_q;
   assign IRQ_HIGH = irq_hi_q;
   assign STATUS = '{high_level: hil_q, low_level: lol_q, overflow: ove_q,
                     fill: level[4:0]};

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   a_ptr_wrap: assert property (push && !fifo_clr && wr_ptr_q == rffc_pkg::PTR_LAST
      |=> wr_ptr_q == 5'h00) else $error("write pointer did not wrap after 23");
   a_clear_all: assert property (fifo_clr |=> wr_ptr_q == 5'h00 && rd_ptr_q == 5'h00
      && STATUS.fill == 5'h00) else $error("fifo reset left pointers or count");
   a_in_count: assert property (push && !fifo_clr
      |=> in_cnt_q == $past(in_cnt_q) + 12'h001) else $error("input counter missed a byte");
   a_out_count: assert property (pop && !fifo_clr
      |=> out_cnt_q == $past(out_cnt_q) + 12'h001) else $error("output counter missed a byte");
   a_level_bound: assert property (level <= rffc_pkg::LEVEL_FULL)
      else $error("fill level exceeds depth");
   a_low_request: assert property (TX_ACTIVE && level < rffc_pkg::LEVEL_LOW
      |=> IRQ_LOW) else $error("low level request missing");
   a_high_request: assert property (RX_ACTIVE && level > rffc_pkg::LEVEL_HIGH
      |=> IRQ_HIGH) else $error("high level request missing");
   a_txlen_limit: assert property (pop_tx |-> out_cnt_q < txlen_q)
      else $error("byte passed beyond transmit length");
   a_last_pulse: assert property (TX_LAST |-> $past(pop_tx)
      && out_cnt_q == txlen_q ##1 !TX_LAST) else $error("last byte signal wrong");
   a_overflow_set: assert property (ove_set |=> STATUS.overflow
      && in_cnt_q == $past(in_cnt_q)) else $error("overflow not flagged or byte stored");
   a_flags_clear: assert property (fifo_clr && !ove_set && !lol_set && !hil_set
      |=> !STATUS.overflow && !STATUS.low_level && !STATUS.high_level)
      else $error("fifo reset did not clear flags");
endmodule : rffc_fifo
`default_nettype wire

// ### rffc_link_sink.sv
// Purpose: Transmit coder stand-in that clocks bytes out of the block
// Assumes: Link clock toggles only while EN is high and rests low otherwise
// Notes: Captured bytes are queued for the bench to inspect
`timescale 1ns/1ns
`default_nettype none
module rffc_link_sink (
   input wire logic EN,
   input wire logic TX_VALID,
   input wire logic [7:0] TX_DATA,
   output logic LINK_CLK
);
   logic [7:0] got[$];
   initial begin
      LINK_CLK = 1'b0;
      #37;
      forever begin
         #400;
         LINK_CLK = EN ? ~LINK_CLK : 1'b0;
      end
   end
   // Takes the head byte at each rising link edge
   always @(posedge LINK_CLK) begin
      if (TX_VALID === 1'b1) got.push_back(TX_DATA);
   end
endmodule : rffc_link_sink
`default_nettype wire

// ### reader_fifo_flow_control_tb.sv
// Purpose: Self-checking bench for the FIFO flow control block
// Assumes: Host accesses are single-cycle pulses on CLK
// Notes: Transmit, overflow, receive and wrap are covered
`timescale 1ns/1ns
`default_nettype none
module reader_fifo_flow_control_tb;
   logic clk;
   logic resetn = 1'b0;
   logic cmd_stb = 1'b0;
   logic tx_act = 1'b0;
   logic rx_act = 1'b0;
   logic rx_vld = 1'b0;
   logic en = 1'b0;
   logic [7:0] cmd_code = 8'h00;
   logic [7:0] rx_data = 8'h00;
   rffc_pkg::rffc_host_req_s req = '0;
   logic link_clk, tx_vld, tx_last, irq_lo, irq_hi;
   logic [7:0] rdata, tx_data;
   rffc_pkg::rffc_status_s st;
   int error_cnt = 0;
   int cmp_count = 0;
   int last_cnt = 0;
   rffc_fifo uut (.CLK(clk), .RESETN(resetn), .HOST_REQ(req), .HOST_RDATA(rdata),
      .CMD_STB(cmd_stb), .CMD_CODE(cmd_code), .TX_ACTIVE(tx_act), .RX_ACTIVE(rx_act),
      .RX_VALID(rx_vld), .RX_DATA(rx_data), .LINK_CLK(link_clk), .TX_DATA(tx_data),
      .TX_VALID(tx_vld), .TX_LAST(tx_last), .IRQ_LOW(irq_lo), .IRQ_HIGH(irq_hi), .STATUS(st));
   rffc_link_sink p (.EN(en), .TX_VALID(tx_vld), .TX_DATA(tx_data), .LINK_CLK(link_clk));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (tx_last === 1'b1) last_cnt++;
   end
   task chk(input logic [11:0] exp, input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: exp %h got %h", $time, exp, got);
      end
   endtask : chk
   task acc(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      #1;
   endtask : acc
   task fifo_rst;
      @(posedge clk);
      cmd_code <= rffc_pkg::CMD_RESET_FIFO;
      cmd_stb <= 1'b1;
      @(posedge clk);
      cmd_stb <= 1'b0;
      @(posedge clk);
      #1;
   endtask : fifo_rst
   task t_transmit;
      int n;
      fifo_rst;
      acc(1'b1, 1'b0, rffc_pkg::ADDR_TXLEN_LO, 8'h03);
      acc(1'b1, 1'b0, rffc_pkg::ADDR_TXLEN_HI, 8'h00);
      acc(1'b0, 1'b1, rffc_pkg::ADDR_TXLEN_LO, 8'h00);
      chk({4'h0, rdata}, 12'h003);
      for (int i = 0; i < 5; i++) acc(1'b1, 1'b0, rffc_pkg::ADDR_FIFO, 8'hA0 + 8'(i));
      chk({7'h0, st.fill}, 12'h005);
      last_cnt = 0;
      @(posedge clk);
      tx_act <= 1'b1;
      repeat (3) @(posedge clk);
      en <= 1'b1;
      #1;
      chk({3'h0, tx_vld, tx_data}, 12'h1A0);
      n = 0;
      while (p.got.size() < 3 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      repeat (60) @(posedge clk);
      #1;
      chk(12'(p.got.size()), 12'h003);
      for (int i = 0; i < 3; i++) chk({4'h0, p.got[i]}, {4'h0, 8'hA0 + 8'(i)});
      chk(12'(last_cnt), 12'h001);
      chk({7'h0, st.fill}, 12'h002);
      chk({10'h0, irq_lo, st.low_level}, 12'h003);
      @(posedge clk);
      tx_act <= 1'b0;
      en <= 1'b0;
      fifo_rst;
      chk({3'h0, tx_vld, st}, 12'h000);
   endtask : t_transmit
   task t_overflow_rx;
      fifo_rst;
      @(posedge clk);
      rx_act <= 1'b1;
      rx_vld <= 1'b1;
      rx_data <= 8'h5A;
      @(posedge clk);
      rx_vld <= 1'b0;
      for (int i = 0; i < 24; i++) acc(1'b1, 1'b0, rffc_pkg::ADDR_FIFO, 8'(i));
      chk({4'h0, st}, 12'h0B8);
      chk({11'h0, irq_hi}, 12'h001);
      @(posedge clk);
      rx_act <= 1'b0;
      acc(1'b0, 1'b1, rffc_pkg::ADDR_FIFO, 8'h00);
      chk({4'h0, rdata}, 12'h05A);
      for (int i = 0; i < 23; i++) begin
         acc(1'b0, 1'b1, rffc_pkg::ADDR_FIFO, 8'h00);
         chk({4'h0, rdata}, 12'(i));
      end
      chk({7'h0, st.fill}, 12'h000);
      acc(1'b1, 1'b0, rffc_pkg::ADDR_FIFO, 8'hC1);
      acc(1'b0, 1'b1, rffc_pkg::ADDR_FIFO, 8'h00);
      chk({4'h0, rdata}, 12'h0C1);
      acc(1'b0, 1'b1, rffc_pkg::ADDR_FIFO, 8'h00);
      chk({4'h0, rdata}, 12'h000);
   endtask : t_overflow_rx
   task tally_and_finish;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
      chk({1'b0, tx_vld, irq_lo, irq_hi, st}, 12'h000);
      t_transmit;
      t_overflow_rx;
      tally_and_finish;
   end
   initial begin
      #3000000;
      error_cnt++;
      tally_and_finish;
   end
endmodule : reader_fifo_flow_control_tb
`default_nettype wire
